// *** cpt_cmd_timer.sv ***
`timescale 1ns/1ns
// Functional notes
// - Channel field picks target; 0101 is timers.
// - Pending flag high while busy, cleared after.
// - Soft reset write clears word within two clocks.
// - Word reads as written; completion clears flag only.
// - Every command completes within 120 clocks.
// - 2560 bytes of shared dual-port memory.
// - Bus master access three clocks, engine one.
// - Concurrent access with a write stalls engine.
// - 768-byte fixed parameter region in memory.
// - Microcode mode hides low and top blocks.
// - Descriptor: status, length, pointer high, low.
// - Sixteen timers, one-shot or restart each.
// - Tick is programmable multiple of 1024 clocks.
// - Timer servicing lowest priority; ticks may drop.
// - Parameter block layout at fixed offsets.
// - Scan pointer written by device only.
// - Mode and valid bits change via setup.
// - Setup: enable, restart, index, period fields.
// - Period zero means 65536 ticks.
// - Tick count advances each tick after scan.
// - Setup command alters exactly one timer.
// - Entry holds initial word then current word.
// - Per tick decrement, event, reload or invalidate.
module cpt_cmd_timer import cpt_pkg::*; (
    // Clock and reset
    input  logic        clk,
    input  logic        rst_n,
    // Command word port
    input  logic        cmd_we,
    input  logic [15:0] cmd_wdata,
    output logic [15:0] cmd_rdata,
    // Bus master port to dual-port memory
    input  logic        hreq,
    input  logic        hwe,
    input  logic [11:0] haddr,
    input  logic [15:0] hwdata,
    output logic        hack,
    output logic [15:0] hrdata,
    // Engine configuration
    input  logic        tick_on,
    input  logic [5:0]  tick_mult,
    input  logic [1:0]  ucode_sel,
    // Timer events
    output logic [15:0] tmr_event
);

    logic [15:0] mem [RAM_WORDS];
    logic [15:0] cmd_q;
    cpt_state_e  st_q;
    logic [6:0]  step_q;
    logic [3:0]  ptr_q;
    logic [15:0] mode_q, valid_q, base_q, ev_q;
    logic [15:0] mode_n, valid_n, erd_q, hrd_q, hwd_q;
    logic [31:0] tmp_q;
    logic [9:0]  pre_q;
    logic [5:0]  mul_q;
    logic        pend_q, hwe_q;
    logic [1:0]  hcnt_q;
    logic [11:0] hadr_q, eng_adr, ent_adr;
    logic [15:0] eng_wd;
    logic [3:0]  idx;
    logic        eng_en, eng_we, eng_go, host_op, h_ok;
    logic        srst, tick, cmd_done, is_tset, h_prot;

    assign cmd_rdata = cmd_q;
    assign hrdata    = hrd_q;
    assign tmr_event = ev_q;

    // ========================================
    // Command word
    assign srst    = cmd_we && cmd_wdata[CW_SRST];
    assign is_tset = cmd_q[11:8] == OPC_SET_TIMER
                  && cmd_q[7:4] == CH_TIMER;

    // Writes while busy are dropped; only soft reset overrides
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_q <= 16'h0000;
        end else if (srst) begin
            cmd_q <= 16'h0000;
        end else if (cmd_we && !cmd_q[CW_FLG]) begin
            cmd_q <= cmd_wdata;
        end else if (cmd_done) begin
            cmd_q[CW_FLG] <= 1'b0;
        end
    end

    // ========================================
    // Tick divider
    assign tick = tick_on && pre_q == PRE_MAX
               && mul_q == tick_mult;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= 10'h000;
            mul_q <= 6'h00;
        end else if (!tick_on) begin
            pre_q <= 10'h000;
            mul_q <= 6'h00;
        end else begin
            pre_q <= pre_q + 10'h001;
            if (pre_q == PRE_MAX) begin
                mul_q <= tick ? 6'h00 : mul_q + 6'h01;
            end
        end
    end

    // A tick landing on a still-pending one is merged and lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= 1'b0;
        end else if (tick) begin
            pend_q <= 1'b1;
        end else if (srst) begin
            pend_q <= 1'b0;
        end else if (st_q == ST_IDLE && !cmd_q[CW_FLG] && eng_go) begin
            pend_q <= 1'b0;
        end
    end

    // ========================================
    // Bus master port
    assign hack    = hcnt_q == 2'h2;
    assign host_op = hcnt_q == 2'h1;
    assign h_prot  = hadr_q >= TPB_BYTE + TP_PTR
                  && hadr_q < TPB_BYTE + TP_SETUP;

    always_comb begin
        h_ok = hadr_q < RAM_TOP;
        if (ucode_sel == UC_SMALL && (hadr_q < UC_BLK
            || hadr_q >= UC_TAIL)) begin
            h_ok = 1'b0;
        end
        if (ucode_sel == UC_LARGE && (hadr_q < UC_BLK + UC_BLK
            || hadr_q >= UC_TAIL)) begin
            h_ok = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hcnt_q <= 2'h0;
            hwe_q  <= 1'b0;
            hadr_q <= 12'h000;
            hwd_q  <= 16'h0000;
            hrd_q  <= 16'h0000;
        end else begin
            if (hcnt_q == 2'h0 && hreq) begin
                hcnt_q <= 2'h1;
                hwe_q  <= hwe;
                hadr_q <= haddr;
                hwd_q  <= hwdata;
            end else if (hcnt_q != 2'h0) begin
                hcnt_q <= hcnt_q == 2'h2 ? 2'h0 : 2'h2;
            end
            if (host_op && !hwe_q) begin
                hrd_q <= h_ok ? mem[hadr_q[11:1]] : 16'h0000;
            end
        end
    end

    // ========================================
    // Memory and engine port
    // Memory is single-write; a colliding write costs the engine a clock
    assign eng_go = !(host_op && eng_en
                   && (hwe_q || eng_we));

    always_ff @(posedge clk) begin
        if (host_op && hwe_q && h_ok && !h_prot) begin
            mem[hadr_q[11:1]] <= hwd_q;
        end else if (eng_en && eng_we && eng_go) begin
            mem[eng_adr[11:1]] <= eng_wd;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            erd_q <= 16'h0000;
        end else if (eng_en && !eng_we && eng_go) begin
            erd_q <= mem[eng_adr[11:1]];
        end
    end

    assign idx     = st_q == ST_CMD ? tmp_q[19:16] : ptr_q;
    assign ent_adr = base_q[11:0] + {6'h00, idx, 2'b00};

    always_comb begin
        mode_n  = mode_q;
        valid_n = valid_q;
        valid_n[idx] = tmp_q[SP_EN];
        if (tmp_q[SP_EN]) begin
            mode_n[idx] = tmp_q[SP_RST];
        end
    end

    always_comb begin
        eng_en   = 1'b0;
        eng_we   = 1'b0;
        eng_adr  = TPB_BYTE;
        eng_wd   = 16'h0000;
        cmd_done = 1'b0;
        case (st_q)
            ST_CMD: begin
                if (is_tset) begin
                    eng_en = step_q != 7'h3;
                    eng_we = step_q > 7'h3;
                    case (step_q)
                        7'h0: eng_adr = TPB_BYTE + TP_ENTRY;
                        7'h1: eng_adr = TPB_BYTE + TP_SETUP;
                        7'h2: eng_adr = TPB_BYTE + TP_SETUP + 12'h2;
                        7'h4: begin
                            eng_adr = ent_adr;
                            eng_wd  = tmp_q[15:0];
                        end
                        7'h5: begin
                            eng_adr = ent_adr + 12'h2;
                            eng_wd  = tmp_q[15:0];
                        end
                        7'h6: begin
                            eng_adr = TPB_BYTE + TP_MODE;
                            eng_wd  = mode_n;
                        end
                        7'h7: begin
                            eng_adr  = TPB_BYTE + TP_VALID;
                            eng_wd   = valid_n;
                            cmd_done = eng_go;
                        end
                        default: eng_en = 1'b0;
                    endcase
                end else begin
                    cmd_done = step_q == CMD_NOP_CYC;
                end
            end
            ST_SCAN: begin
                case (step_q)
                    7'h0: begin
                        eng_en  = 1'b1;
                        eng_adr = TPB_BYTE + TP_ENTRY;
                    end
                    7'h2: begin
                        eng_en  = valid_q[ptr_q];
                        eng_adr = ent_adr + 12'h2;
                    end
                    7'h3: begin
                        eng_en  = 1'b1;
                        eng_we  = 1'b1;
                        eng_adr = ent_adr + 12'h2;
                        eng_wd  = erd_q - 16'h0001;
                    end
                    7'h4: begin
                        eng_en  = 1'b1;
                        eng_adr = ent_adr;
                    end
                    7'h5: begin
                        eng_en  = 1'b1;
                        eng_we  = 1'b1;
                        eng_adr = ent_adr + 12'h2;
                        eng_wd  = erd_q;
                    end
                    default: eng_en = 1'b0;
                endcase
            end
            ST_CNT: begin
                eng_en = step_q != 7'h2;
                eng_we = step_q > 7'h2;
                case (step_q)
                    7'h0: eng_adr = TPB_BYTE + TP_TICKS;
                    7'h1: eng_adr = TPB_BYTE + TP_TICKS + 12'h2;
                    7'h3: begin
                        eng_adr = TPB_BYTE + TP_TICKS;
                        eng_wd  = tmp_q[31:16];
                    end
                    7'h4: begin
                        eng_adr = TPB_BYTE + TP_TICKS + 12'h2;
                        eng_wd  = tmp_q[15:0];
                    end
                    7'h5: begin
                        eng_adr = TPB_BYTE + TP_MODE;
                        eng_wd  = mode_q;
                    end
                    7'h6: begin
                        eng_adr = TPB_BYTE + TP_VALID;
                        eng_wd  = valid_q;
                    end
                    7'h7: begin
                        eng_adr = TPB_BYTE + TP_PTR;
                        eng_wd  = {12'h000, ptr_q};
                    end
                    default: eng_en = 1'b0;
                endcase
            end
            default: eng_en = 1'b0;
        endcase
    end

    // ========================================
    // Engine sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q    <= ST_IDLE;
            step_q  <= 7'h00;
            ptr_q   <= 4'h0;
            base_q  <= 16'h0000;
            tmp_q   <= 32'h0;
            mode_q  <= 16'h0000;
            valid_q <= 16'h0000;
            ev_q    <= 16'h0000;
        end else if (srst) begin
            st_q    <= ST_IDLE;
            step_q  <= 7'h00;
            ptr_q   <= 4'h0;
            mode_q  <= 16'h0000;
            valid_q <= 16'h0000;
            ev_q    <= 16'h0000;
        end else begin
            ev_q <= 16'h0000;
            if (eng_go) begin
                step_q <= step_q + 7'h01;
                case (st_q)
                    ST_IDLE: begin
                        step_q <= 7'h00;
                        ptr_q  <= 4'h0;
                        if (cmd_q[CW_FLG]) begin
                            st_q <= ST_CMD;
                        end else if (pend_q) begin
                            st_q <= ST_SCAN;
                        end
                    end
                    ST_CMD: begin
                        if (is_tset) begin
                            case (step_q)
                                7'h1: base_q <= erd_q;
                                7'h2: tmp_q[31:16] <= erd_q;
                                7'h3: begin
                                    tmp_q[15:0] <= erd_q;
                                    if (!tmp_q[SP_EN]) begin
                                        step_q <= 7'h06;
                                    end
                                end
                                7'h7: begin
                                    mode_q  <= mode_n;
                                    valid_q <= valid_n;
                                    st_q    <= ST_IDLE;
                                end
                                default: ;
                            endcase
                        end else if (cmd_done) begin
                            st_q <= ST_IDLE;
                        end
                    end
                    ST_SCAN: begin
                        case (step_q)
                            7'h1: base_q <= erd_q;
                            7'h2: begin
                                if (!valid_q[ptr_q]) begin
                                    step_q <= 7'h02;
                                    ptr_q  <= ptr_q + 4'h1;
                                    if (ptr_q == 4'hf) begin
                                        st_q   <= ST_CNT;
                                        step_q <= 7'h00;
                                    end
                                end
                            end
                            7'h3: begin
                                if (erd_q == 16'h0001) begin
                                    ev_q[ptr_q] <= 1'b1;
                                end
                                if (erd_q != 16'h0001 || !mode_q[ptr_q]) begin
                                    if (erd_q == 16'h0001) begin
                                        valid_q[ptr_q] <= 1'b0;
                                    end
                                    step_q <= 7'h02;
                                    ptr_q  <= ptr_q + 4'h1;
                                    if (ptr_q == 4'hf) begin
                                        st_q   <= ST_CNT;
                                        step_q <= 7'h00;
                                    end
                                end
                            end
                            7'h5: begin
                                step_q <= 7'h02;
                                ptr_q  <= ptr_q + 4'h1;
                                if (ptr_q == 4'hf) begin
                                    st_q   <= ST_CNT;
                                    step_q <= 7'h00;
                                end
                            end
                            default: ;
                        endcase
                    end
                    ST_CNT: begin
                        case (step_q)
                            7'h1: tmp_q[31:16] <= erd_q;
                            7'h2: tmp_q <= {tmp_q[31:16], erd_q}
                                         + 32'h1;
                            7'h7: st_q <= ST_IDLE;
                            default: ;
                        endcase
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end

    // ========================================
    // Assertions
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_SRST_CLEAR: assert property (srst |=> cmd_q == 16'h0000)
        else $error("soft reset left command word set");
    AST_CMD_HOLD: assert property (cmd_q[CW_FLG] && !cmd_done
        && !srst |=> $stable(cmd_q))
        else $error("command word changed during execution");
    AST_CMD_DONE: assert property (cmd_done && !srst
        |=> cmd_q == ($past(cmd_q) & 16'hfffe))
        else $error("completion did not clear only the flag");
    AST_CMD_LAT: assert property ($rose(cmd_q[CW_FLG])
        |-> ##[1:120] !cmd_q[CW_FLG])
        else $error("command took longer than 120 clocks");
    AST_HOST_3CLK: assert property (hreq && hcnt_q == 2'h0
        |-> !hack ##1 !hack ##1 hack)
        else $error("bus master access not three clocks");
    AST_ENG_STALL: assert property (!eng_go && !srst
        |=> $stable(step_q) && $stable(st_q))
        else $error("engine advanced during collision");
    AST_VALID_SRC: assert property ($changed(valid_q)
        |-> $past(st_q != ST_IDLE || srst))
        else $error("valid bits changed outside engine");
    AST_EVT_TIMEOUT: assert property (|ev_q |-> $past(st_q == ST_SCAN
        && step_q == 7'h3 && erd_q == 16'h0001))
        else $error("timer event without timeout");

    CV_SET_TIMER: cover property (cmd_done && is_tset);
    CV_EVENT:     cover property (|ev_q);
    CV_STALL:     cover property (!eng_go);

endmodule

// *** cpt_pkg.sv ***
package cpt_pkg;

    // ========================================
    // Dual-port memory
    localparam int          RAM_BYTES = 2560;
    localparam int          RAM_WORDS = RAM_BYTES / 2;
    localparam logic [11:0] RAM_TOP   = 12'ha00;
    localparam logic [11:0] PRAM_BYTE = 12'h700;
    localparam int          PRAM_LEN  = 768;
    localparam logic [11:0] UC_BLK    = 12'h200;
    localparam logic [11:0] UC_TAIL   = 12'h900;
    localparam logic [1:0]  UC_NONE   = 2'h0;
    localparam logic [1:0]  UC_SMALL  = 2'h1;
    localparam logic [1:0]  UC_LARGE  = 2'h2;

    // ========================================
    // Buffer descriptor word offsets
    localparam logic [3:0]  BD_STAT   = 4'h0;
    localparam logic [3:0]  BD_LEN    = 4'h2;
    localparam logic [3:0]  BD_PTR_HI = 4'h4;
    localparam logic [3:0]  BD_PTR_LO = 4'h6;

    // ========================================
    // Timer parameter block
    localparam logic [11:0] TPB_BYTE  = 12'h8b0;
    localparam logic [11:0] TP_ENTRY  = 12'h000;
    localparam logic [11:0] TP_PTR    = 12'h002;
    localparam logic [11:0] TP_MODE   = 12'h004;
    localparam logic [11:0] TP_VALID  = 12'h006;
    localparam logic [11:0] TP_SETUP  = 12'h008;
    localparam logic [11:0] TP_TICKS  = 12'h00c;
    localparam int          SP_EN     = 31;
    localparam int          SP_RST    = 30;
    localparam int          NTMR      = 16;

    // ========================================
    // Command word
    localparam int          CW_SRST   = 15;
    localparam int          CW_FLG    = 0;
    localparam logic [3:0]  OPC_SET_TIMER = 4'h8;
    localparam logic [3:0]  CH_SER1   = 4'h0;
    localparam logic [3:0]  CH_SER2   = 4'h4;
    localparam logic [3:0]  CH_TIMER  = 4'h5;
    localparam logic [3:0]  CH_SER3   = 4'h8;
    localparam logic [3:0]  CH_SS1    = 4'h9;
    localparam logic [3:0]  CH_SER4   = 4'hc;
    localparam logic [3:0]  CH_SS2    = 4'hd;

    // ========================================
    // Timing in clocks
    localparam logic [9:0]  PRE_MAX     = 10'h3ff; // 1024 clocks
    localparam logic [6:0]  CMD_NOP_CYC = 7'h28;   // 40 clocks
    localparam int          CMD_MAX_CYC = 120;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_CMD  = 4'h2,
        ST_SCAN = 4'h4,
        ST_CNT  = 4'h8
    } cpt_state_e;

endpackage

// *** cpt_host.sv ***
`timescale 1ns/1ns
module cpt_host (
    // Clock
    input  wire logic        clk,
    // Command word port
    output logic             cmd_we,
    output logic [15:0]      cmd_wdata,
    input  wire logic [15:0] cmd_rdata,
    // Memory port
    output logic             hreq,
    output logic             hwe,
    output logic [11:0]      haddr,
    output logic [15:0]      hwdata,
    input  wire logic        hack,
    input  wire logic [15:0] hrdata
);
    // ========================================
    // Idle bus: released lines never repeat their last value, except hwe, which keeps it
    initial begin
        cmd_we = 1'b0;
        cmd_wdata = 16'h0000;
        hreq = 1'b0;
        hwe = 1'b0;
        haddr = 12'h000;
        hwdata = 16'h0000;
    end

    // ========================================
    // Memory access, held until the acknowledge edge
    task automatic mem(input logic w, input logic [11:0] a,
                       input logic [15:0] d, output logic [15:0] q,
                       output int n);
        n = 0;
        @(negedge clk);
        hreq <= 1'b1;
        hwe <= w;
        haddr <= a;
        hwdata <= d;
        do begin
            @(negedge clk);
            n++;
        end while (hack !== 1'b1 && n < 50);
        q = hrdata;
        @(negedge clk);
        hreq <= 1'b0;
        haddr <= ~a;
        hwdata <= ~d;
    endtask

    // ========================================
    // Command word write, flag always set by caller
    task automatic cmd(input logic [15:0] w);
        @(negedge clk);
        cmd_we <= 1'b1;
        cmd_wdata <= w;
        @(negedge clk);
        cmd_we <= 1'b0;
        cmd_wdata <= ~w;
    endtask

    // Waiting on the flag keeps commands apart
    task automatic wait_idle(output int n);
        n = 0;
        while (cmd_rdata[0] !== 1'b0 && n < 300) begin
            @(negedge clk);
            n++;
        end
    endtask

    // Setup long is written big-endian before the command
    task automatic set_timer(input logic [31:0] p, output int n);
        logic [15:0] q;
        mem(1'b1, 12'h8b8, p[31:16], q, n);
        mem(1'b1, 12'h8ba, p[15:0], q, n);
        cmd(16'h0851);
    endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/1ns
module testbench import cpt_pkg::*; ;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        tick_on = 1'b0;
    logic [5:0]  tick_mult = 6'h00;
    logic [1:0]  ucode_sel = UC_NONE;
    logic        cmd_we, hreq, hwe, hack;
    logic [15:0] cmd_wdata, cmd_rdata, hwdata, hrdata, tmr_event, q, w;
    logic [11:0] haddr;
    logic [11:0] a;
    int          err_total = 0;
    int          comparisons = 0;
    int          seed = 58;
    int          n, c0;
    int          mem_m [int];
    logic [3:0]  chans [8] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h5, 4'h9, 4'hd, 4'h2};

    always #5 clk = ~clk;

    cpt_host host (.clk(clk), .cmd_we(cmd_we), .cmd_wdata(cmd_wdata),
        .cmd_rdata(cmd_rdata), .hreq(hreq), .hwe(hwe), .haddr(haddr),
        .hwdata(hwdata), .hack(hack), .hrdata(hrdata));
    cpt_cmd_timer dut (.clk(clk), .rst_n(rst_n), .cmd_we(cmd_we),
        .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .hreq(hreq),
        .hwe(hwe), .haddr(haddr), .hwdata(hwdata), .hack(hack),
        .hrdata(hrdata), .tick_on(tick_on), .tick_mult(tick_mult),
        .ucode_sel(ucode_sel), .tmr_event(tmr_event));

    // ========================================
    // Compare tasks
    task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_lat(input int g, input int lim);
        comparisons++;
        if (g > lim) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, lim);
        end
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ========================================
    // Memory model: unmapped space reads zero
    task automatic wr(input logic [11:0] ad, input logic [15:0] d);
        host.mem(1'b1, ad, d, q, n);
        chk_lat(n, 3);
        if (ad < RAM_TOP && (ad < 12'h8b2 || ad > 12'h8b7))
            mem_m[ad >> 1] = d;
    endtask
    task automatic rd(input logic [11:0] ad);
        host.mem(1'b0, ad, 16'h0000, q, n);
        chk_lat(n, 3);
        chk_word(q, ad >= RAM_TOP ? 16'h0000 : 16'(mem_m[ad >> 1]));
    endtask

    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        chk_word(cmd_rdata, 16'h0000);
        chk_word(tmr_event, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            a = 12'(($random(seed) & 32'h37e));
            wr(a, 16'($random(seed)));
            rd(a);
        end
        rd(12'ha00);
        wr(12'h400, 16'h5a5a);
        ucode_sel = UC_SMALL;
        mem_m[12'h100 >> 1] = 0;
        rd(12'h100);
        rd(12'h400);
        ucode_sel = UC_LARGE;
        mem_m[12'h3fe >> 1] = 0;
        mem_m[12'h900 >> 1] = 0;
        rd(12'h3fe);
        rd(12'h400);
        rd(12'h900);
        ucode_sel = UC_NONE;
        $display("test memory done");
        // Soft reset lands on a pending command so the clear is visible
        host.cmd(16'h0381);
        host.cmd(16'h8001);
        chk_word(cmd_rdata, 16'h0000);
        @(negedge clk);
        chk_word(cmd_rdata, 16'h0000);
        foreach (chans[i]) begin
            w = 16'h0301 | (16'(chans[i]) << 4);
            host.cmd(w);
            if (i == 0)
                host.cmd(16'h0241);
            chk_word(cmd_rdata, w);
            host.wait_idle(n);
            chk_lat(n, CMD_MAX_CYC);
            chk_word(cmd_rdata, w & 16'hfffe);
        end
        $display("test command done");
        wr(12'h8b0, 16'h0000);
        wr(12'h8bc, 16'h0000);
        wr(12'h8be, 16'h0000);
        host.set_timer(32'h8000_0002, n);
        host.wait_idle(n);
        chk_lat(n, CMD_MAX_CYC);
        host.set_timer(32'hc003_0003, n);
        host.wait_idle(n);
        host.set_timer(32'h8001_0000, n);
        host.wait_idle(n);
        chk_lat(n, CMD_MAX_CYC);
        mem_m[12'h8b4 >> 1] = 16'h0008;
        mem_m[12'h8b6 >> 1] = 16'h000b;
        mem_m[0] = 16'h0002;
        mem_m[12'h004 >> 1] = 16'h0000;
        mem_m[12'h00c >> 1] = 16'h0003;
        rd(12'h8b4);
        rd(12'h8b6);
        rd(12'h000);
        rd(12'h004);
        rd(12'h00c);
        wr(12'h8b6, 16'hffff);
        rd(12'h8b6);
        tick_on = 1'b1;
        n = 0;
        while (tmr_event[0] !== 1'b1 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        chk_lat(n, 3 * 1024);
        chk_lat(2 * 1024 - 200, n);
        chk_word(tmr_event, 16'h0001);
        // Valid word reaches memory only at the end of the scan
        repeat (40) @(negedge clk);
        mem_m[12'h8b6 >> 1] = 16'h000a;
        mem_m[12'h006 >> 1] = 16'hfffe;
        rd(12'h8b6);
        rd(12'h006);
        n = 0;
        while (tmr_event[3] !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        tick_mult = 6'h01;
        chk_lat(n, 1024);
        chk_word(tmr_event, 16'h0008);
        // Sample the count well clear of the scan that writes it
        repeat (100) @(negedge clk);
        rd(12'h8b6);
        host.mem(1'b0, 12'h8be, 16'h0000, q, n);
        c0 = q;
        repeat (2048 - 4) @(negedge clk);
        host.mem(1'b0, 12'h8be, 16'h0000, q, n);
        chk_word(q, 16'(c0 + 1));
        $display("test timers done");
        test_done();
    end

    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        test_done();
    end
endmodule
